// file: rtl/spm_defines.vh
`ifndef SPM_DEFINES_VH
`define SPM_DEFINES_VH

// Register byte offsets
`define SPM_OFS_OPT        8'h00
`define SPM_OFS_PAD        8'h04
`define SPM_OFS_STAT       8'h08
`define SPM_OFS_DIV        8'h0c

// system_options_one fields
`define SPM_OPT_DBG_EN     0
`define SPM_OPT_RST_EN     1
`define SPM_OPT_EXTERNAL_TIMER_CLOCK_IN_EN    2
`define SPM_OPT_IRQ_EN     3
`define SPM_OPT_CMP_EN     4
`define SPM_OPT_W          5
`define SPM_OPT_RESET      5'h01

// Pad control fields
`define SPM_PAD_A5_PULL    0
`define SPM_PAD_A4_DRIVE   1
`define SPM_PAD_A4_SLEW    2
`define SPM_PAD_A4_DATA    3
`define SPM_PAD_W          4
`define SPM_PAD_RESET      4'h0

// Status fields
`define SPM_STAT_SINGLE_WIRE_DEBUG_PIN      0
`define SPM_STAT_A5_OWN    1
`define SPM_STAT_A4_OWN    3
`define SPM_STAT_A5_LVL    5
`define SPM_STAT_A4_LVL    6

// Debug clock divider
`define SPM_DIV_W          8
`define SPM_DIV_RESET      8'h00

// Debug clocks per bit time on the single wire
`define SPM_BIT_CYCLES     16
`define SPM_BIT_LAST       4'hf

// Owner codes: port, first, second, third alternate
`define SPM_OWN_PORT       2'h0
`define SPM_OWN_ALT1       2'h1
`define SPM_OWN_ALT2       2'h2
`define SPM_OWN_ALT3       2'h3

`endif

// file: rtl/spm_mux.v
// Local design decisions: register access over APB and the register offsets.
`include "spm_defines.vh"

module spm_mux #(
	parameter DIV_W = `SPM_DIV_W
) (
	input  wire        clk,
	input  wire        rst,
	input  wire        por_rst,
	input  wire        force_rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        a5_pin_in,
	output reg         a5_pin_out,
	output reg         a5_pin_oe,
	output reg         a5_pullup,
	output reg         a5_hyst,
	input  wire        a4_pin_in,
	output reg         a4_pin_out,
	output reg         a4_pin_oe,
	output reg         a4_pullup,
	output reg         a4_hyst,
	output reg         a4_drive_hi,
	output reg         a4_slew_en,
	input  wire        comparator_output_alt,
	input  wire        dbg_drive_low,
	input  wire        dbg_speedup,
	output reg         dbg_rx,
	output reg         dbg_clk_en,
	output reg         dbg_bit_strobe,
	output reg         single_wire_debug_pin_mode,
	output reg         ext_reset_req,
	output reg         irq_request_level,
	output reg         branch_irq_level,
	output reg         external_timer_clock_in,
	output reg         input_only_port_bit
);

	function [1:0] own_of;
		input alt1;
		input alt2;
		input alt3;
		begin
			if (alt3)
				own_of = `SPM_OWN_ALT3;
			else if (alt2)
				own_of = `SPM_OWN_ALT2;
			else if (alt1)
				own_of = `SPM_OWN_ALT1;
			else
				own_of = `SPM_OWN_PORT;
		end
	endfunction

	reg  [`SPM_OPT_W-1:0] opt_q;
	reg  [`SPM_PAD_W-1:0] pad_q;
	reg  [DIV_W-1:0]      div_q;
	reg  [DIV_W-1:0]      div_cnt_q;
	reg  [3:0]            bit_cnt_q;
	reg                   in_reset_q;
	reg                   in_reset2_q;
	reg                   mode_kind_q;
	wire [1:0]            pin_lvl;
	reg  [31:0]           rdata_d;
	reg                   hit_d;
	wire [1:0]            pin_raw;
	wire                  a5_lvl;
	wire                  a4_lvl;
	wire                  wr_en;
	wire                  setup;
	wire [1:0]            a5_own;
	wire [1:0]            a4_own;
	wire                  div_hit;
	wire                  mode_judge;

	assign pin_raw = {a4_pin_in, a5_pin_in};
	assign a5_lvl  = pin_lvl[0];
	assign a4_lvl  = pin_lvl[1];
	assign setup   = psel && !penable;
	assign wr_en   = psel && penable && pready && pwrite && !pslverr;
	assign mode_judge = in_reset2_q && !in_reset_q && !rst;

	// Three-stage pin synchronisers, level moves when stages two and three agree
	// No reset: the pins must stay visible while reset is held
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
			reg [2:0] sync_q;
			reg       lvl_q;
			always @(posedge clk) begin
				sync_q <= {sync_q[1:0], pin_raw[gi]};
				if (sync_q[1] == sync_q[2])
					lvl_q <= sync_q[2];
			end
			assign pin_lvl[gi] = lvl_q;
		end
	endgenerate

	// Priority owners
	assign a5_own = own_of(opt_q[`SPM_OPT_IRQ_EN], opt_q[`SPM_OPT_EXTERNAL_TIMER_CLOCK_IN_EN],
		opt_q[`SPM_OPT_RST_EN]);
	assign a4_own = own_of(opt_q[`SPM_OPT_CMP_EN], opt_q[`SPM_OPT_DBG_EN],
		rst);

	// Register file
	always @(posedge clk) begin
		if (rst) begin
			opt_q[`SPM_OPT_DBG_EN]  <= 1'b1;
			opt_q[`SPM_OPT_EXTERNAL_TIMER_CLOCK_IN_EN] <= 1'b0;
			opt_q[`SPM_OPT_IRQ_EN]  <= 1'b0;
			opt_q[`SPM_OPT_CMP_EN]  <= 1'b0;
			if (por_rst)
				opt_q[`SPM_OPT_RST_EN] <= 1'b0;
			pad_q <= `SPM_PAD_RESET;
			div_q <= `SPM_DIV_RESET;
		end else if (wr_en) begin
			case (paddr)
				`SPM_OFS_OPT: begin
					opt_q <= pwdata[`SPM_OPT_W-1:0];
				end
				`SPM_OFS_PAD: begin
					pad_q <= pwdata[`SPM_PAD_W-1:0];
				end
				`SPM_OFS_DIV: begin
					div_q <= pwdata[DIV_W-1:0];
				end
				default: begin
					opt_q <= opt_q;
				end
			endcase
		end
	end

	// Read decode
	always @* begin
		rdata_d = 32'h00000000;
		hit_d   = 1'b1;
		case (paddr)
			`SPM_OFS_OPT: begin
				rdata_d[`SPM_OPT_W-1:0] = opt_q;
			end
			`SPM_OFS_PAD: begin
				rdata_d[`SPM_PAD_W-1:0] = pad_q;
			end
			`SPM_OFS_STAT: begin
				rdata_d[`SPM_STAT_SINGLE_WIRE_DEBUG_PIN]        = single_wire_debug_pin_mode;
				rdata_d[`SPM_STAT_A5_OWN+1 -: 2] = a5_own;
				rdata_d[`SPM_STAT_A4_OWN+1 -: 2] = a4_own;
				rdata_d[`SPM_STAT_A5_LVL]      = a5_lvl;
				rdata_d[`SPM_STAT_A4_LVL]      = a4_lvl;
			end
			`SPM_OFS_DIV: begin
				rdata_d[DIV_W-1:0] = div_q;
			end
			default: begin
				hit_d = 1'b0;
			end
		endcase
	end

	// APB answer, one access cycle
	always @(posedge clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= setup;
			pslverr <= setup && !hit_d;
			if (setup)
				prdata <= (hit_d && !pwrite) ? rdata_d : 32'h00000000;
		end
	end

	// Reset release pipeline
	always @(posedge clk) begin
		in_reset_q  <= rst;
		in_reset2_q <= in_reset_q;
	end

	// Reset kind sampled while reset is held
	always @(posedge clk) begin
		if (rst)
			mode_kind_q <= por_rst || force_rst;
	end

	// Pin level judged two edges after release, once synchronised
	always @(posedge clk) begin
		if (rst && por_rst)
			single_wire_debug_pin_mode <= 1'b0;
		else if (mode_judge)
			single_wire_debug_pin_mode <= mode_kind_q && !a4_lvl;
	end

	// Debug clock enable and bit time strobe
	assign div_hit = (div_cnt_q >= div_q);

	always @(posedge clk) begin
		if (rst) begin
			div_cnt_q  <= {DIV_W{1'b0}};
			dbg_clk_en <= 1'b0;
		end else begin
			dbg_clk_en <= div_hit;
			if (div_hit)
				div_cnt_q <= {DIV_W{1'b0}};
			else
				div_cnt_q <= div_cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
		end
	end

	// Bit time strobe
	always @(posedge clk) begin
		if (rst) begin
			bit_cnt_q      <= 4'h0;
			dbg_bit_strobe <= 1'b0;
		end else begin
			dbg_bit_strobe <= 1'b0;
			if (div_hit && bit_cnt_q == `SPM_BIT_LAST) begin
				bit_cnt_q      <= 4'h0;
				dbg_bit_strobe <= 1'b1;
			end else if (div_hit) begin
				bit_cnt_q <= bit_cnt_q + 4'h1;
			end
		end
	end

	// Shared input-only pin: reset, timer clock, interrupt, port
	always @(posedge clk) begin
		if (rst) begin
			a5_pin_out              <= 1'b0;
			a5_pin_oe               <= 1'b0;
			a5_pullup               <= 1'b0;
			a5_hyst                 <= 1'b0;
			ext_reset_req           <= 1'b0;
			irq_request_level       <= 1'b1;
			branch_irq_level        <= 1'b1;
			external_timer_clock_in <= 1'b0;
			input_only_port_bit     <= 1'b1;
		end else begin
			a5_pin_out          <= 1'b0;
			a5_pin_oe           <= 1'b0;
			input_only_port_bit <= a5_lvl;
			ext_reset_req       <= 1'b0;
			irq_request_level   <= 1'b1;
			branch_irq_level    <= 1'b1;
			external_timer_clock_in <= 1'b0;
			a5_hyst             <= 1'b0;
			a5_pullup           <= pad_q[`SPM_PAD_A5_PULL];
			case (a5_own)
				`SPM_OWN_ALT3: begin
					a5_pullup     <= 1'b1;
					a5_hyst       <= 1'b1;
					ext_reset_req <= !a5_lvl;
				end
				`SPM_OWN_ALT2: begin
					external_timer_clock_in <= a5_lvl;
				end
				`SPM_OWN_ALT1: begin
					irq_request_level <= a5_lvl;
					branch_irq_level  <= a5_lvl;
				end
				default: begin
					a5_hyst <= 1'b0;
				end
			endcase
		end
	end

	// Mode/debug pin: mode select, debug, comparator, output-only port
	always @(posedge clk) begin
		if (rst) begin
			a4_pin_out  <= 1'b0;
			a4_pin_oe   <= 1'b0;
			a4_pullup   <= 1'b1;
			a4_hyst     <= 1'b1;
			a4_drive_hi <= 1'b0;
			a4_slew_en  <= 1'b0;
			dbg_rx      <= 1'b1;
		end else begin
			dbg_rx <= 1'b1;
			case (a4_own)
				`SPM_OWN_ALT2: begin
					a4_pin_out  <= dbg_speedup;
					a4_pin_oe   <= dbg_drive_low || dbg_speedup;
					a4_pullup   <= 1'b1;
					a4_hyst     <= 1'b1;
					a4_drive_hi <= 1'b0;
					a4_slew_en  <= 1'b0;
					dbg_rx      <= a4_lvl;
				end
				`SPM_OWN_ALT1: begin
					a4_pin_out  <= comparator_output_alt;
					a4_pin_oe   <= 1'b1;
					a4_pullup   <= 1'b0;
					a4_hyst     <= 1'b0;
					a4_drive_hi <= pad_q[`SPM_PAD_A4_DRIVE];
					a4_slew_en  <= pad_q[`SPM_PAD_A4_SLEW];
				end
				default: begin
					a4_pin_out  <= pad_q[`SPM_PAD_A4_DATA];
					a4_pin_oe   <= 1'b1;
					a4_pullup   <= 1'b0;
					a4_hyst     <= 1'b0;
					a4_drive_hi <= pad_q[`SPM_PAD_A4_DRIVE];
					a4_slew_en  <= pad_q[`SPM_PAD_A4_SLEW];
				end
			endcase
		end
	end

endmodule // spm_mux

// file: bench/spm_mux_checker.sv
module spm_mux_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic a5_pin_oe,
	input wire logic a5_pin_out,
	input wire logic a5_pullup,
	input wire logic a5_hyst,
	input wire logic a4_pullup,
	input wire logic a4_hyst,
	input wire logic a4_slew_en,
	input wire logic a4_drive_hi,
	input wire logic dbg_bit_strobe,
	input wire logic single_wire_debug_pin_mode,
	input wire logic ext_reset_req,
	input wire logic irq_request_level,
	input wire logic branch_irq_level,
	input wire logic external_timer_clock_in
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	property p_a5_undriven;
		!a5_pin_oe && !a5_pin_out;
	endproperty
	a_a5_undriven: assert property (p_a5_undriven)
		else $error("shared input pin driven");
	property p_rst_pull;
		a5_hyst |-> a5_pullup;
	endproperty
	a_rst_pull: assert property (p_rst_pull)
		else $error("reset pin without pull-up");
	property p_req_owner;
		ext_reset_req |-> a5_hyst;
	endproperty
	a_req_owner: assert property (p_req_owner)
		else $error("reset request while pin not owned");
	property p_irq_pair;
		irq_request_level == branch_irq_level;
	endproperty
	a_irq_pair: assert property (p_irq_pair)
		else $error("interrupt and branch levels differ");
	property p_external_timer_clock_in_prio;
		a5_hyst |-> !external_timer_clock_in;
	endproperty
	a_external_timer_clock_in_prio: assert property (p_external_timer_clock_in_prio)
		else $error("timer clock active under reset owner");
	property p_dbg_pad;
		a4_hyst |-> a4_pullup && !a4_slew_en && !a4_drive_hi;
	endproperty
	a_dbg_pad: assert property (p_dbg_pad)
		else $error("debug pin pad setup wrong");
	property p_mode_hold;
		!$past(rst) && !$past(rst, 2) && !$past(rst, 3)
			|-> $stable(single_wire_debug_pin_mode);
	endproperty
	a_mode_hold: assert property (p_mode_hold)
		else $error("mode changed after reset end");
	property p_strobe_gap;
		dbg_bit_strobe |=> !dbg_bit_strobe [*8];
	endproperty
	a_strobe_gap: assert property (p_strobe_gap)
		else $error("bit strobes too close");
endmodule // spm_mux_checker

bind spm_mux spm_mux_checker u_chk (.*);

// file: bench/spm_host.sv
module spm_host (
	input  wire logic hold_low,
	input  wire logic a4_pin_oe,
	input  wire logic a4_pin_out,
	output logic      a4_line
);
	timeunit 1ns;
	timeprecision 1ps;
	// Target drive wins, else host pull-down, else pull-up
	always_comb begin
		if (a4_pin_oe)
			a4_line = a4_pin_out;
		else if (hold_low)
			a4_line = 1'b0;
		else
			a4_line = 1'b1;
	end
endmodule // spm_host

// file: bench/spm_mux_tb.sv
`include "spm_defines.vh"
module spm_mux_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, por_rst, force_rst, psel, penable, pwrite, pready;
	logic pslverr, a5_pin_in, a5_pin_out, a5_pin_oe, a5_pullup, a5_hyst;
	logic a4_pin_in, a4_pin_out, a4_pin_oe, a4_pullup, a4_hyst;
	logic a4_drive_hi, a4_slew_en, comparator_output_alt, dbg_drive_low;
	logic dbg_speedup, dbg_rx, dbg_clk_en, dbg_bit_strobe, single_wire_debug_pin_mode;
	logic ext_reset_req, irq_request_level, branch_irq_level;
	logic external_timer_clock_in, input_only_port_bit, hold, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	int n_mismatch, num_checks, cyc, n, m;
	logic [7:0] ov [5] = '{8'h00, 8'h08, 8'h0c, 8'h0e, 8'h0c};
	logic [5:0] ev [5] = '{6'h06, 6'h00, 6'h06, 6'h36, 6'h0f};
	spm_mux u_dut (.*);
	spm_host u_host (.hold_low(hold), .a4_pin_oe(a4_pin_oe),
		.a4_pin_out(a4_pin_out), .a4_line(a4_pin_in));
	task automatic give_verdict();
		if (n_mismatch == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
		num_checks++;
		if (got !== ex) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", nm, ex, got);
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] ex);
		apb(1'b0, a, 32'h0);
		chk("rdata", ex, r);
	endtask
	task automatic wt(int k);
		repeat (k) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic rst_seq(logic p, logic f);
		@(posedge clk);
		rst <= 1'b1;
		por_rst <= p;
		force_rst <= f;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		por_rst <= 1'b0;
		force_rst <= 1'b0;
		wt(2);
	endtask
	task automatic gap();
		do @(negedge clk); while (dbg_bit_strobe !== 1'b1);
		n = 0;
		m = 0;
		do begin
			@(negedge clk);
			n++;
			if (dbg_clk_en === 1'b1)
				m++;
		end while (dbg_bit_strobe !== 1'b1);
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		{rst, por_rst, hold, a5_pin_in} = 4'hf;
		{force_rst, psel, penable, pwrite, dbg_drive_low} = 5'h0;
		{dbg_speedup, comparator_output_alt} = 2'h0;
		{paddr, pwdata, cyc} = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		por_rst <= 1'b0;
		wt(2);
		chk("single_wire_debug_pin", 1, single_wire_debug_pin_mode);
		chk("rx", 0, dbg_rx);
		rd(`SPM_OFS_OPT, 32'h01);
		chk("a5pad", 0, {a5_pullup, a5_hyst});
		chk("a4pad", 6, {a4_pullup, a4_hyst, a4_slew_en});
		@(posedge clk);
		hold <= 1'b0;
		dbg_drive_low <= 1'b1;
		wt(1);
		chk("low", 2, {a4_pin_oe, a4_pin_out});
		@(posedge clk);
		dbg_drive_low <= 1'b0;
		dbg_speedup <= 1'b1;
		wt(1);
		chk("up", 3, {a4_pin_oe, a4_pin_out});
		@(posedge clk);
		dbg_speedup <= 1'b0;
		wt(6);
		chk("rel", 1, {a4_pin_oe, dbg_rx});
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, `SPM_OFS_DIV, i);
			gap();
			gap();
			chk("bit", 16 * (i + 1), n);
			chk("ticks", 16, m);
		end
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			a5_pin_in <= (i == 4);
			apb(1'b1, `SPM_OFS_OPT, ov[i]);
			wt(6);
			apb(1'b0, `SPM_OFS_STAT, 0);
			chk("own", i < 4 ? i : 2, r[2:1]);
			chk("a5", ev[i], {ext_reset_req, a5_hyst,
				external_timer_clock_in, irq_request_level,
				branch_irq_level, input_only_port_bit});
		end
		apb(1'b1, `SPM_OFS_OPT, 32'h02);
		rst_seq(1'b0, 1'b0);
		rd(`SPM_OFS_OPT, 32'h03);
		chk("single_wire_debug_pin", 0, single_wire_debug_pin_mode);
		hold <= 1'b1;
		wt(4);
		rst_seq(1'b0, 1'b1);
		chk("single_wire_debug_pin", 1, single_wire_debug_pin_mode);
		@(posedge clk);
		hold <= 1'b0;
		wt(4);
		rst_seq(1'b1, 1'b0);
		rd(`SPM_OFS_OPT, 32'h01);
		chk("single_wire_debug_pin", 0, single_wire_debug_pin_mode);
		apb(1'b1, `SPM_OFS_OPT, 32'h00);
		apb(1'b1, `SPM_OFS_PAD, 32'h0f);
		wt(2);
		chk("pad", 5'h1f, {a5_pullup, a4_pin_oe, a4_pin_out,
			a4_drive_hi, a4_slew_en});
		apb(1'b1, `SPM_OFS_OPT, 32'h10);
		comparator_output_alt <= 1'b1;
		wt(2);
		chk("cmp", 3, {a4_pin_oe, a4_pin_out});
		apb(1'b0, 8'h10, 0);
		chk("err", 1, e);
		give_verdict();
	end
endmodule // spm_mux_tb
